// ---- logic/nco_pkg.sv ----
// Shared constants for the phase accumulator and sine lookup datapath.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package nco_pkg;
   localparam int          NCO_ACC_W      = 28;
   localparam int          NCO_PH_W       = 12;
   localparam int          NCO_AMP_W      = 10;
   localparam int          NCO_ADDR_W     = 3;
   localparam int          NCO_DATA_W     = 32;
   localparam int          NCO_SYNC_W     = 3;
   // Pin change to DAC output word, in master clock cycles.
   localparam int          NCO_SEL_LATENCY = 8;
   localparam real         NCO_PI         = 3.14159265358979;

   // Register indices on the address port.
   localparam logic [2:0]  NCO_REG_TW_A   = 3'h0;
   localparam logic [2:0]  NCO_REG_TW_B   = 3'h1;
   localparam logic [2:0]  NCO_REG_PO_A   = 3'h2;
   localparam logic [2:0]  NCO_REG_PO_B   = 3'h3;
   localparam logic [2:0]  NCO_REG_CTRL   = 3'h4;
   localparam logic [2:0]  NCO_REG_STATUS = 3'h5;

   // Control register bit positions.
   localparam int          NCO_CTRL_W      = 6;
   localparam int          NCO_CTRL_TSEL   = 0;
   localparam int          NCO_CTRL_MODE   = 1;
   localparam int          NCO_CTRL_OSEL   = 2;
   localparam int          NCO_CTRL_PINSEL = 3;
   localparam int          NCO_CTRL_OBE    = 5;
   localparam logic [5:0]  NCO_CTRL_RST    = 6'h00;
endpackage

// ---- logic/nco_core.sv ----
// Phase accumulator, phase offset adder, sine lookup and a two-entry
// output buffer feeding a 10-bit converter. Assumes one clock, register
// writes over a plain strobe port, and a converter with valid/ready.
//
// Functional notes
// - The phase accumulator is 28 bits and its full range is one cycle.
// - Each clock the datapath advances, the accumulator adds the selected tuning word.
// - The tuning word comes from word a or b, chosen by pin or bit.
// - Changing the tuning choice changes only the increment, never the phase.
// - A selected 12-bit offset is added to the top accumulator bits.
// - The modulated phase is cut to its upper 12 bits for conversion.
// - The lookup table is addressed by the truncated phase.
// - Amplitude codes are 10 bits, two fewer than the phase address.
// - Control bits D5 and D1 enable or bypass the sine lookup.
// - The offset register is chosen by the offset pin or a control bit.
// - The datapath reset input zeroes the phase path, not the registers.
// - A select pin change reaches the output eight cycles after the edge that first samples it.
`timescale 1ns/10ps
module nco_core
   import nco_pkg::*;
#(
   parameter int ACC_W = NCO_ACC_W,
   parameter int PH_W  = NCO_PH_W,
   parameter int AMP_W = NCO_AMP_W
)
(
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic [NCO_ADDR_W-1:0] reg_addr_in,
   input  wire logic [NCO_DATA_W-1:0] reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   input  wire logic                  tuning_select_pin_in,
   input  wire logic                  offset_select_pin_in,
   input  wire logic                  dp_reset_in,
   input  wire logic                  dac_ready_in,
   output logic      [NCO_DATA_W-1:0] reg_rdata_out,
   output logic      [AMP_W-1:0]      dac_data_out,
   output logic                       dac_valid_out,
   output logic                       sign_bit_out
);
   localparam int QN = 2 ** (PH_W - 2);
   localparam int HALF = 2 ** (AMP_W - 1) - 1;
   localparam logic [AMP_W-1:0] MID = AMP_W'(2 ** (AMP_W - 1));

   if (ACC_W <= PH_W || PH_W != AMP_W + 2 || ACC_W > NCO_DATA_W)
      $error("nco_core: widths not supported");

   typedef struct packed {
      logic [ACC_W-1:0]      tw_a;
      logic [ACC_W-1:0]      tw_b;
      logic [PH_W-1:0]       po_a;
      logic [PH_W-1:0]       po_b;
      logic [NCO_CTRL_W-1:0] ctrl;
      logic [NCO_SYNC_W-1:0] tsync;
      logic [NCO_SYNC_W-1:0] osync;
      logic [NCO_SYNC_W-1:0] rsync;
      logic                  tsel;
      logic                  osel;
      logic                  dprst;
      logic [ACC_W-1:0]      inc;
      logic [ACC_W-1:0]      acc;
      logic [PH_W-1:0]       off1;
      logic [PH_W-1:0]       off2;
      logic [PH_W-1:0]       ph;
      logic [AMP_W-1:0]      amp;
      logic                  amp_v;
      logic                  amp_sign;
      logic [AMP_W-1:0]      out_data;
      logic                  out_valid;
      logic [AMP_W-1:0]      sk_data;
      logic                  sk_valid;
      logic                  sign;
      logic [NCO_DATA_W-1:0] rdata;
   } nco_state_type;

   nco_state_type r;
   nco_state_type next_r;

   // Quarter wave, computed at elaboration; entry QN is the peak.
   logic [AMP_W-2:0] q_tab [0:QN];

   for (genvar i = 0; i <= QN; i++)
   begin : g_tab
      localparam int V = int'($floor(HALF * $sin(i * NCO_PI / (2.0 * QN))
                                     + 0.5));
      assign q_tab[i] = (AMP_W-1)'(V);
   end

   // Offset binary sine: first phase half above midscale, second half below.
   function automatic logic [AMP_W-1:0] sine_amp(input logic [PH_W-1:0] p);
      logic [PH_W-2:0] idx;
      logic [AMP_W-2:0] q;
      idx = p[PH_W-2:0];
      if (p[PH_W-2])
         q = q_tab[QN - int'(idx[PH_W-3:0])];
      else
         q = q_tab[idx[PH_W-3:0]];
      if (p[PH_W-1])
         sine_amp = MID - AMP_W'(q);
      else
         sine_amp = MID + AMP_W'(q);
   endfunction

   // Triangle from the address when the lookup is bypassed.
   function automatic logic [AMP_W-1:0] tri_amp(input logic [PH_W-1:0] p);
      logic [AMP_W-1:0] ramp;
      ramp = p[PH_W-2:PH_W-AMP_W-1];
      if (p[PH_W-1])
         tri_amp = ~ramp;
      else
         tri_amp = ramp;
   endfunction

   function automatic logic agree(input logic [NCO_SYNC_W-1:0] s);
      agree = s[1] == s[2];
   endfunction

   logic sel_t;
   logic sel_o;
   logic advance;
   logic rom_on;

   always_comb
   begin
      next_r = r;
      next_r.rdata = '0;
      sel_t = r.ctrl[NCO_CTRL_PINSEL] ? r.tsel : r.ctrl[NCO_CTRL_TSEL];
      sel_o = r.ctrl[NCO_CTRL_PINSEL] ? r.osel : r.ctrl[NCO_CTRL_OSEL];
      // Datapath stalls only when both buffer entries are full.
      advance = !r.sk_valid;
      rom_on = !r.ctrl[NCO_CTRL_MODE] || r.ctrl[NCO_CTRL_OBE];

      if (reg_wr_in)
      begin
         case (reg_addr_in)
            NCO_REG_TW_A: next_r.tw_a = reg_wdata_in[ACC_W-1:0];
            NCO_REG_TW_B: next_r.tw_b = reg_wdata_in[ACC_W-1:0];
            NCO_REG_PO_A: next_r.po_a = reg_wdata_in[PH_W-1:0];
            NCO_REG_PO_B: next_r.po_b = reg_wdata_in[PH_W-1:0];
            NCO_REG_CTRL: next_r.ctrl = reg_wdata_in[NCO_CTRL_W-1:0];
            default: next_r.ctrl = r.ctrl;
         endcase
      end
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            NCO_REG_TW_A:   next_r.rdata = NCO_DATA_W'(r.tw_a);
            NCO_REG_TW_B:   next_r.rdata = NCO_DATA_W'(r.tw_b);
            NCO_REG_PO_A:   next_r.rdata = NCO_DATA_W'(r.po_a);
            NCO_REG_PO_B:   next_r.rdata = NCO_DATA_W'(r.po_b);
            NCO_REG_CTRL:   next_r.rdata = NCO_DATA_W'(r.ctrl);
            NCO_REG_STATUS: next_r.rdata = NCO_DATA_W'(r.acc);
            default:        next_r.rdata = '0;
         endcase
      end

      // Pins pass three flops; a level is taken once stages two and three
      // agree, so a single-cycle glitch never reaches the selects.
      next_r.tsync = {r.tsync[1:0], tuning_select_pin_in};
      next_r.osync = {r.osync[1:0], offset_select_pin_in};
      next_r.rsync = {r.rsync[1:0], dp_reset_in};
      if (agree(r.tsync))
         next_r.tsel = r.tsync[2];
      if (agree(r.osync))
         next_r.osel = r.osync[2];
      if (agree(r.rsync))
         next_r.dprst = r.rsync[2];

      if (advance)
      begin
         next_r.inc = sel_t ? r.tw_b : r.tw_a;
         next_r.off1 = sel_o ? r.po_b : r.po_a;
         // The second offset stage lines the offset up with the increment
         // so both selects land at the output in the same cycle.
         next_r.off2 = r.off1;
         // Only the increment follows the select; the sum carries on.
         next_r.acc = r.acc + r.inc;
         next_r.ph = r.acc[ACC_W-1:ACC_W-PH_W] + r.off2;
         next_r.amp = rom_on ? sine_amp(r.ph) : tri_amp(r.ph);
         next_r.amp_sign = r.ph[PH_W-1];
         next_r.amp_v = 1'b1;
         if (r.dprst)
         begin
            next_r.acc = '0;
            next_r.off1 = '0;
            next_r.off2 = '0;
            next_r.ph = '0;
         end
      end

      // Two-entry buffer: the skid entry catches the word in flight when
      // the converter stalls, and its fullness stalls the datapath.
      if (r.out_valid && !dac_ready_in)
      begin
         if (advance && r.amp_v)
         begin
            next_r.sk_data = r.amp;
            next_r.sk_valid = 1'b1;
         end
      end
      else if (r.sk_valid)
      begin
         next_r.out_data = r.sk_data;
         next_r.out_valid = 1'b1;
         next_r.sk_valid = 1'b0;
      end
      else
      begin
         next_r.out_data = r.amp;
         next_r.out_valid = r.amp_v;
      end

      next_r.sign = r.ctrl[NCO_CTRL_OBE] && r.amp_sign;
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         r <= '0;
         r.ctrl <= NCO_CTRL_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign reg_rdata_out = r.rdata;
   assign dac_data_out = r.out_data;
   assign dac_valid_out = r.out_valid;
   assign sign_bit_out = r.sign;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_run;
      !r.sk_valid && !r.dprst;
   endsequence

   sequence s_pin_settles;
      r.tsync[2] == r.tsync[1] && r.tsel != r.tsync[2];
   endsequence

   AST_ACC_STEP: assert property (
      s_run |=> r.acc == ACC_W'($past(r.acc) + $past(r.inc)))
      else $error("accumulator did not add the increment");

   AST_INC_SOURCE: assert property (
      !r.sk_valid && !reg_wr_in ##1 !r.sk_valid
      |-> r.inc == ($past(sel_t) ? $past(r.tw_b) : $past(r.tw_a)))
      else $error("increment not taken from the selected word");

   AST_NO_PHASE_JUMP: assert property (
      $changed(r.tsel) && $past(!r.sk_valid && !r.dprst)
      |-> r.acc == ACC_W'($past(r.acc) + $past(r.inc)))
      else $error("phase jumped on select change");

   AST_OFFSET_ADD: assert property (
      !r.sk_valid && !r.dprst |=> r.ph ==
      PH_W'($past(r.acc[ACC_W-1:ACC_W-PH_W]) + $past(r.off2)))
      else $error("offset sum wrong");

   AST_DP_RESET: assert property (
      r.dprst && !r.sk_valid && !reg_wr_in
      |=> r.acc == '0 && r.ph == '0 && $stable(r.tw_a) && $stable(r.po_a))
      else $error("datapath reset misbehaved");

   AST_PIN_TAKEN: assert property (
      s_pin_settles |=> r.tsel == $past(r.tsync[2]))
      else $error("settled pin level not taken");

   AST_MIDSCALE: assert property (
      !r.sk_valid && r.ph == '0 && rom_on |=> r.amp == MID)
      else $error("zero phase not at midscale");

   AST_BUF_HOLD: assert property (
      r.out_valid && !dac_ready_in |=> r.out_valid && $stable(r.out_data))
      else $error("stalled word changed or lost");

   // A held skid word leaves first once the converter takes words again.
   sequence s_drain;
      r.sk_valid && dac_ready_in;
   endsequence

   sequence s_glitch;
      r.tsync[2] != r.tsync[1];
   endsequence

   AST_SKID_DRAIN: assert property (
      s_drain |=> r.out_valid && !r.sk_valid
      && r.out_data == $past(r.sk_data))
      else $error("skid word not drained first");

   // A full skid entry must freeze the whole phase path, or words are lost.
   AST_FREEZE: assert property (
      r.sk_valid |=> $stable(r.acc) && $stable(r.amp))
      else $error("datapath moved while the buffer was full");

   AST_VALID_FILL: assert property (
      r.amp_v && !r.out_valid |=> r.out_valid)
      else $error("ready word not presented");

   AST_OFF_SOURCE: assert property (
      !r.sk_valid && !r.dprst
      |=> r.off1 == ($past(sel_o) ? $past(r.po_b) : $past(r.po_a)))
      else $error("offset not taken from the selected register");

   AST_OFF_ALIGN: assert property (
      !r.sk_valid && !r.dprst |=> r.off2 == $past(r.off1))
      else $error("offset stage skipped");

   AST_SYNC_FILTER: assert property (
      s_glitch |=> $stable(r.tsel))
      else $error("unsettled pin level taken");

   AST_BYPASS_ZERO: assert property (
      !r.sk_valid && !rom_on && r.ph == '0 |=> r.amp == '0)
      else $error("bypassed lookup did not pass the phase");

   // Peak and trough pin the table ends to codes 1023 and 1.
   AST_PEAK: assert property (
      !r.sk_valid && rom_on && r.ph == PH_W'(QN) |=> r.amp == '1)
      else $error("quarter phase not at full scale");

   AST_TROUGH: assert property (
      !r.sk_valid && rom_on && r.ph == PH_W'(3 * QN)
      |=> r.amp == AMP_W'(1))
      else $error("three quarter phase not at bottom code");

   AST_STATUS_READ: assert property (
      reg_rd_in && reg_addr_in == NCO_REG_STATUS
      |=> r.rdata == NCO_DATA_W'($past(r.acc)))
      else $error("status read did not return the accumulator");

   AST_RDATA_IDLE: assert property (
      !reg_rd_in |=> r.rdata == '0)
      else $error("read data stood without a read");

   AST_SIGN_OFF: assert property (
      !r.ctrl[NCO_CTRL_OBE] |=> !r.sign)
      else $error("sign output driven while disabled");
endmodule

// ---- verif/nco_dac_sink.sv ----
// Converter model for the amplitude stream of the oscillator core.
// Assumes one clock; mode 0 always ready, 1 random stalls, 2 stopped.
`timescale 1ns/10ps
module nco_dac_sink
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic [1:0] mode_in,
   output logic            ready_out
);
   // Stalls are drawn per cycle so both buffer entries get filled.
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         ready_out <= 1'b0;
      else
         ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && $urandom % 2);
   end
endmodule

// ---- verif/nco_core_tb.sv ----
// Self-checking bench for the oscillator core and its converter stream.
// Assumes the converter model and a 100 MHz clock.
`timescale 1ns/10ps
module nco_core_tb;
   import nco_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        tpin = 1'b0;
   logic        opin = 1'b0;
   logic        dprst = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic        chk_on = 1'b0;
   logic        ready, valid, sign, have, hv;
   logic [31:0] rdata, a0, a1, wa, wb;
   logic [9:0]  dac, prev, hd;
   logic [11:0] p;
   logic        o;
   int          err_count = 0;
   int          tests_run = 0;
   int          cyc = 0;

   nco_core DUT
   (
      .ref_clk_in           (clk),
      .rst_b_in             (rst_b),
      .reg_addr_in          (addr),
      .reg_wdata_in         (wdata),
      .reg_wr_in            (wr),
      .reg_rd_in            (rd),
      .tuning_select_pin_in (tpin),
      .offset_select_pin_in (opin),
      .dp_reset_in          (dprst),
      .dac_ready_in         (ready),
      .reg_rdata_out        (rdata),
      .dac_data_out         (dac),
      .dac_valid_out        (valid),
      .sign_bit_out         (sign)
   );
   nco_dac_sink sink
   (
      .ref_clk_in (clk),
      .rst_b_in   (rst_b),
      .mode_in    (mode),
      .ready_out  (ready)
   );

   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [9:0] sine_of(input logic [11:0] ph);
      real r;
      r = 511.0 * $sin(2.0 * NCO_PI * ph / 4096.0);
      return 10'(512 + $rtoi(r < 0.0 ? r - 0.5 : r + 0.5));
   endfunction

   // A lost or repeated word breaks the fixed phase step of 8.
   function automatic bit pair_ok(input logic [9:0] a, input logic [9:0] b);
      for (int i = 0; i < 4096; i++)
         if (sine_of(12'(i)) == a && sine_of(12'(i + 8)) == b)
            return 1'b1;
      return 1'b0;
   endfunction

   function automatic bit cont_ok(input logic [27:0] d);
      for (int i = 0; i <= 4; i++)
         if (d == 28'(i * wa + (4 - i) * wb))
            return 1'b1;
      return 1'b0;
   endfunction

   task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic span2(input logic [31:0] w);
      repeat (4) @(posedge clk);
      rd_reg(NCO_REG_STATUS, a0);
      rd_reg(NCO_REG_STATUS, a1);
      check(a1 - a0 & 32'h0FFFFFFF, 2 * w & 32'h0FFFFFFF);
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_count = err_count + 1;
         report_and_stop();
      end
      if (hv)
         check({valid, dac}, {1'b1, hd});
      if (chk_on && valid && ready)
      begin
         if (have)
            check(32'(pair_ok(prev, dac)), 32'h1);
         have = 1'b1;
         prev = dac;
      end
      if (!chk_on)
         have = 1'b0;
      hv = valid && !ready;
      hd = dac;
   end

   initial
   begin
      void'($urandom(32'hA31A));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(NCO_REG_CTRL, a0);
      check(a0, 32'h0);
      wr_reg(NCO_REG_PO_A, 32'hFFFFFFFF);
      rd_reg(NCO_REG_PO_A, a0);
      check(a0, 32'h00000FFF);
      @(posedge clk);
      #1 check(rdata, 32'h0);
      rd_reg(3'h6, a0);
      check(a0, 32'h0);
      $display("test 1 done");
      for (int i = 0; i < 4; i++)
      begin
         wa = (i == 0) ? 32'hFFFFFFFF : $urandom;
         wr_reg(NCO_REG_TW_A, wa);
         wa = wa & 32'h0FFFFFFF;
         span2(wa);
      end
      $display("test 2 done");
      wb = $urandom & 32'h0FFFFFFF;
      wr_reg(NCO_REG_TW_B, wb);
      wr_reg(NCO_REG_CTRL, 32'h1);
      span2(wb);
      rd_reg(NCO_REG_STATUS, a0);
      wr_reg(NCO_REG_CTRL, 32'h8);
      rd_reg(NCO_REG_STATUS, a1);
      check(32'(cont_ok(28'(a1 - a0))), 32'h1);
      span2(wa);
      @(posedge clk) tpin <= 1'b1;
      span2(wb);
      $display("test 3 done");
      @(posedge clk) dprst <= 1'b1;
      repeat (12) @(posedge clk);
      rd_reg(NCO_REG_STATUS, a0);
      check(a0, 32'h0);
      check({22'h0, dac}, 32'h200);
      @(posedge clk) dprst <= 1'b0;
      rd_reg(NCO_REG_TW_B, a0);
      check(a0, wb);
      $display("test 4 done");
      // Zero increments freeze the phase, so only the offset moves it.
      wr_reg(NCO_REG_TW_A, 32'h0);
      wr_reg(NCO_REG_TW_B, 32'h0);
      @(posedge clk) dprst <= 1'b1;
      repeat (8) @(posedge clk);
      dprst <= 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         p = (i < 4) ? 12'(i * 1024) : 12'($urandom);
         o = 1'(i % 2);
         wr_reg(o ? NCO_REG_PO_B : NCO_REG_PO_A, 32'hFFFFF000 | p);
         wr_reg(NCO_REG_CTRL, o ? 32'h26 : 32'h0);
         repeat (12) @(posedge clk);
         #1 check({22'h0, dac}, {22'h0, sine_of(p)});
         check({31'h0, sign}, {31'h0, o & p[11]});
      end
      wr_reg(NCO_REG_PO_A, 32'h200);
      wr_reg(NCO_REG_CTRL, 32'h2);
      repeat (12) @(posedge clk);
      #1 check({22'h0, dac}, 32'h100);
      $display("test 5 done");
      wr_reg(NCO_REG_PO_A, 32'h0);
      wr_reg(NCO_REG_PO_B, 32'h400);
      wr_reg(NCO_REG_CTRL, 32'h8);
      repeat (12) @(posedge clk);
      opin <= 1'b1;
      repeat (8) @(posedge clk);
      #1 check({22'h0, dac}, 32'h200);
      @(posedge clk);
      #1 check({22'h0, dac}, 32'h3FF);
      $display("test 6 done");
      @(posedge clk) opin <= 1'b0;
      wr_reg(NCO_REG_TW_A, 32'h00080000);
      wr_reg(NCO_REG_CTRL, 32'h0);
      repeat (12) @(posedge clk);
      chk_on <= 1'b1;
      mode   <= 2'h1;
      repeat (300) @(posedge clk);
      mode <= 2'h2;
      repeat (6) @(posedge clk);
      rd_reg(NCO_REG_STATUS, a0);
      rd_reg(NCO_REG_STATUS, a1);
      check(a1, a0);
      @(posedge clk) mode <= 2'h1;
      repeat (300) @(posedge clk);
      chk_on <= 1'b0;
      $display("test 7 done");
      report_and_stop();
   end
endmodule
